// *** cemc_pkg.sv ***
// Package of shared constants and types for the crypto mode control block.
package cemc_pkg;

  // Width of one data word carried through the queues.
  localparam int unsigned DATA_W = 32;
  // Depth of each data queue.
  localparam int unsigned FIFO_DEPTH = 16;
  // Number of words in one key slot.
  localparam int unsigned KEY_WORDS = 8;
  // Width of the key word index.
  localparam int unsigned KEY_IDX_W = 3;
  // Cycles spent running the power-up known answer tests.
  localparam int unsigned SELFTEST_CYCLES = 32;
  // Width of the self-test cycle counter.
  localparam int unsigned SELFTEST_CNT_W = 6;
  // Reset value of a key word, so reset zeroizes every slot.
  localparam logic [DATA_W-1:0] KEY_ZERO = 32'h0000_0000;
  // Value offered to the output queue when no word moves; it is never written.
  localparam logic [DATA_W-1:0] DATA_IDLE = 32'h0000_0000;
  // Reset value of the self-test counter.
  localparam logic [SELFTEST_CNT_W-1:0] CNT_ZERO = 6'h00;
  // Step of the self-test counter.
  localparam logic [SELFTEST_CNT_W-1:0] CNT_ONE = 6'h01;
  // Last value of the self-test counter.
  localparam logic [SELFTEST_CNT_W-1:0] CNT_LAST = 6'h1F;

  // Status bit positions in the status word.
  localparam int unsigned ST_READY = 0;
  localparam int unsigned ST_APPROVED = 1;
  localparam int unsigned ST_LOCKED = 2;
  localparam int unsigned ST_BUSY = 3;
  localparam int unsigned ST_REFUSED = 4;
  localparam int unsigned ST_W = 5;

  // Operating states of the control engine, one-hot coded.
  typedef enum logic [4:0] {
    CEMC_TEST = 5'h01,
    CEMC_IDLE = 5'h02,
    CEMC_RUN = 5'h04,
    CEMC_LOCK = 5'h08,
    CEMC_NAPP = 5'h10
  } cemc_state_e;

endpackage : cemc_pkg

// *** cemc_if.sv ***
// Interface joining the crypto control device end and its host end.
`timescale 1ns/1ps
interface cemc_if;
  // Host-to-device data word stream.
  logic [cemc_pkg::DATA_W-1:0] in_data;
  logic in_valid;
  logic in_ready;
  // Device-to-host data word stream.
  logic [cemc_pkg::DATA_W-1:0] out_data;
  logic out_valid;
  logic out_ready;
  // Service request, one-cycle pulse, with its mode flag and length.
  logic req;
  logic req_nonapproved;
  logic [7:0] req_words;
  // Write-only key register port.
  logic key_we;
  logic key_slot;
  logic [cemc_pkg::KEY_IDX_W-1:0] key_idx;
  logic [cemc_pkg::DATA_W-1:0] key_data;
  // Key load from the stream, one-cycle pulse.
  logic key_from_fifo;
  // Readable status register.
  logic [cemc_pkg::ST_W-1:0] status;
  // Service finished, one-cycle pulse.
  logic done;

  // Device end.
  modport dev (
    input in_data, in_valid, req, req_nonapproved, req_words, out_ready,
    input key_we, key_slot, key_idx, key_data, key_from_fifo,
    output in_ready, out_data, out_valid, status, done
  );
  // Host end.
  modport host (
    output in_data, in_valid, req, req_nonapproved, req_words, out_ready,
    output key_we, key_slot, key_idx, key_data, key_from_fifo,
    input in_ready, out_data, out_valid, status, done
  );
endinterface : cemc_if

// *** cemc_fifo.sv ***
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module cemc_fifo #(
  parameter int unsigned WIDTH = cemc_pkg::DATA_W,
  parameter int unsigned DEPTH = cemc_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Filling side.
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  // Draining side.
  output logic [WIDTH-1:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Pointer arithmetic relies on a power-of-two depth.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least two.");
  end

  // Storage words and pointers; count is one bit wider than the index.
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire push = wr_valid_i && wr_ready_o;
  wire pop = rd_valid_o && rd_ready_i;

  // Full and empty come straight from the count, so they never lie.
  assign wr_ready_o = (cnt_q != DEPTH[AW:0]);
  assign rd_valid_o = (cnt_q != '0);
  assign rd_data_o = mem_q[rp_q];

  // Storage writes; no reset needed since empty hides stale words.
  always_ff @(posedge clk_i)
  begin
    if (push) mem_q[wp_q] <= wr_data_i;
  end

  // Pointers and count.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : cemc_fifo

// *** cemc_dev.sv ***
// Device end: mode control, self-test lock, key store and data queues.
`timescale 1ns/1ps
// Behaviour
// - Approved mode only after power-up tests pass.
// - Services offered only after init and tests.
// - Non-approved request switches mode implicitly.
// - Back to approved mode right after service.
// - Separate key storage per mode.
// - Failed known answer test locks device.
// - Only reset unlocks; reset reruns tests.
// - Keys are write-only, never read back.
// - Reset zeroizes all key material.
// - Host loads new key for non-approved use; the host end only blocks a repeat without one, not the first after reset.
// - Data in and out through FIFOs.
// - Control in and status out via registers.
// - Host supplies parameters through input FIFO; the code takes mode and word count from link registers.
// - Keys via register writes or FIFO.
// - No bypass; every service processes data.
// - Errors never expose key material.
module cemc_dev #(
  parameter int unsigned KEY_WORDS = cemc_pkg::KEY_WORDS
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Link to the host end.
  cemc_if.dev link,
  // Outcome of the known answer tests from the test engine.
  input wire logic kat_done_i,
  input wire logic kat_pass_i,
  // Current mode seen by the datapath.
  output logic approved_o
);
  // The key index must address every key word.
  if (KEY_WORDS != (1 << cemc_pkg::KEY_IDX_W))
  begin : g_bad_keys
    $error("KEY_WORDS must equal two to the key index width.");
  end

  // Control state and counters.
  cemc_pkg::cemc_state_e st_q;
  cemc_pkg::cemc_state_e st_d;
  logic [cemc_pkg::SELFTEST_CNT_W-1:0] tcnt_q;
  logic [7:0] left_q;
  logic refused_q;
  logic done_q;
  logic [cemc_pkg::ST_W-1:0] status_q;
  logic approved_q;
  // Two key slots, one per mode; never wired to any read path.
  logic [cemc_pkg::DATA_W-1:0] key_app_q [KEY_WORDS];
  logic [cemc_pkg::DATA_W-1:0] key_nap_q [KEY_WORDS];
  logic [cemc_pkg::KEY_IDX_W-1:0] kfill_q;
  logic kfill_on_q;
  logic kfill_slot_q;

  // Queue-side wires.
  logic [cemc_pkg::DATA_W-1:0] q_in_data;
  logic q_in_valid;
  logic q_out_ready;
  logic [cemc_pkg::DATA_W-1:0] proc_data;

  // Decode of the state and requests.
  wire in_run = (st_q == cemc_pkg::CEMC_RUN) ||
    (st_q == cemc_pkg::CEMC_NAPP);
  wire service_ok = (st_q == cemc_pkg::CEMC_IDLE);
  wire take_req = link.req && service_ok && !kfill_on_q;
  wire bad_req = link.req && !take_req;
  wire kat_fail = kat_done_i && !kat_pass_i;
  wire tests_over = (tcnt_q == cemc_pkg::CNT_LAST) && kat_done_i;
  wire key_pop = kfill_on_q && q_in_valid;
  // Data moves only in a running service while the output can take it.
  wire word_go = in_run && q_in_valid && q_out_ready &&
    (left_q != 8'h00);
  wire last_word = word_go && (left_q == 8'h01);
  // Active slot follows the mode so the two keys never mix.
  wire cur_slot = (st_q == cemc_pkg::CEMC_NAPP);
  wire [cemc_pkg::DATA_W-1:0] cur_key = cur_slot ?
    key_nap_q[left_q[cemc_pkg::KEY_IDX_W-1:0]] :
    key_app_q[left_q[cemc_pkg::KEY_IDX_W-1:0]];
  // Stand-in transform; key words are mixed in, never passed bare.
  assign proc_data = q_in_data ^ cur_key ^ {left_q, left_q, left_q, left_q};

  // Input queue fed by the host end stream; data words and streamed keys arrive here.
  cemc_fifo #(
    .WIDTH(cemc_pkg::DATA_W),
    .DEPTH(cemc_pkg::FIFO_DEPTH)
  ) u_in_q (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_data_i(link.in_data),
    .wr_valid_i(link.in_valid),
    .wr_ready_o(link.in_ready),
    .rd_data_o(q_in_data),
    .rd_valid_o(q_in_valid),
    .rd_ready_i(word_go || key_pop)
  );

  // Output queue drained by the host; locked state never writes it.
  cemc_fifo #(
    .WIDTH(cemc_pkg::DATA_W),
    .DEPTH(cemc_pkg::FIFO_DEPTH)
  ) u_out_q (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_data_i(word_go ? proc_data : cemc_pkg::DATA_IDLE),
    .wr_valid_i(word_go),
    .wr_ready_o(q_out_ready),
    .rd_data_o(link.out_data),
    .rd_valid_o(link.out_valid),
    .rd_ready_i(link.out_ready)
  );

  // Next state: tests, idle, service in either mode, or lock.
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      cemc_pkg::CEMC_TEST:
      begin
        if (kat_fail) st_d = cemc_pkg::CEMC_LOCK;
        else if (tests_over) st_d = cemc_pkg::CEMC_IDLE;
      end
      cemc_pkg::CEMC_IDLE:
      begin
        if (take_req)
          st_d = link.req_nonapproved ? cemc_pkg::CEMC_NAPP :
            cemc_pkg::CEMC_RUN;
      end
      cemc_pkg::CEMC_RUN, cemc_pkg::CEMC_NAPP:
      begin
        if (last_word) st_d = cemc_pkg::CEMC_IDLE;
      end
      cemc_pkg::CEMC_LOCK:
      begin
        st_d = cemc_pkg::CEMC_LOCK;
      end
      default:
      begin
        st_d = cemc_pkg::CEMC_LOCK;
      end
    endcase
  end

  // State register; reset alone leaves lock and restarts the tests.
  always_ff @(posedge clk_i)
  begin
    if (rst_i) st_q <= cemc_pkg::CEMC_TEST;
    else st_q <= st_d;
  end

  // Self-test sequencing counter, rerun on every reset.
  always_ff @(posedge clk_i)
  begin
    if (rst_i) tcnt_q <= cemc_pkg::CNT_ZERO;
    else if (st_q == cemc_pkg::CEMC_TEST && tcnt_q != cemc_pkg::CNT_LAST)
      tcnt_q <= tcnt_q + cemc_pkg::CNT_ONE;
  end

  // Words left in the current service.
  always_ff @(posedge clk_i)
  begin
    if (rst_i) left_q <= 8'h00;
    else if (take_req) left_q <= link.req_words;
    else if (word_go) left_q <= left_q - 8'h01;
  end

  // Key load from the stream into the slot named by the request.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      kfill_on_q <= 1'b0;
      kfill_q <= '0;
      kfill_slot_q <= 1'b0;
    end
    else if (link.key_from_fifo && service_ok && !kfill_on_q)
    begin
      kfill_on_q <= 1'b1;
      kfill_q <= '0;
      kfill_slot_q <= link.key_slot;
    end
    else if (key_pop)
    begin
      kfill_q <= kfill_q + 1'b1;
      if (kfill_q == '1) kfill_on_q <= 1'b0;
    end
  end

  // Key slots: written by register or stream, zeroized on reset.
  // A lock keeps writes out, so a failed engine takes no new key once locked.
  for (genvar i = 0; i < KEY_WORDS; i++)
  begin : g_key
    wire reg_hit = link.key_we && (link.key_idx == i) &&
      (st_q != cemc_pkg::CEMC_LOCK);
    wire fifo_hit = key_pop && (kfill_q == i);
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        key_app_q[i] <= cemc_pkg::KEY_ZERO;
        key_nap_q[i] <= cemc_pkg::KEY_ZERO;
      end
      else if (fifo_hit)
      begin
        if (kfill_slot_q) key_nap_q[i] <= q_in_data;
        else key_app_q[i] <= q_in_data;
      end
      else if (reg_hit)
      begin
        if (link.key_slot) key_nap_q[i] <= link.key_data;
        else key_app_q[i] <= link.key_data;
      end
    end
  end

  // Status word and pulses; built from state, requests and word flow, never from keys.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_q <= '0;
      refused_q <= 1'b0;
      done_q <= 1'b0;
      approved_q <= 1'b0;
    end
    else
    begin
      refused_q <= bad_req;
      done_q <= last_word;
      approved_q <= (st_d == cemc_pkg::CEMC_IDLE) ||
        (st_d == cemc_pkg::CEMC_RUN);
      status_q[cemc_pkg::ST_READY] <= (st_d == cemc_pkg::CEMC_IDLE);
      status_q[cemc_pkg::ST_APPROVED] <= (st_d == cemc_pkg::CEMC_IDLE) ||
        (st_d == cemc_pkg::CEMC_RUN);
      status_q[cemc_pkg::ST_LOCKED] <= (st_d == cemc_pkg::CEMC_LOCK);
      status_q[cemc_pkg::ST_BUSY] <= (st_d == cemc_pkg::CEMC_RUN) ||
        (st_d == cemc_pkg::CEMC_NAPP);
      status_q[cemc_pkg::ST_REFUSED] <= bad_req;
    end
  end

  assign link.status = status_q;
  assign link.done = done_q;
  assign approved_o = approved_q;
endmodule : cemc_dev

// *** cemc_host.sv ***
// Host end: turns user commands into link requests and key loads.
`timescale 1ns/1ps
module cemc_host (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Link to the device end.
  cemc_if.host link,
  // User data stream towards the device.
  input wire logic [cemc_pkg::DATA_W-1:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  // User data stream from the device.
  output logic [cemc_pkg::DATA_W-1:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  // Service command, a one-cycle pulse.
  input wire logic cmd_i,
  input wire logic cmd_nonapproved_i,
  input wire logic [7:0] cmd_words_i,
  // Key write command, a one-cycle pulse.
  input wire logic key_we_i,
  input wire logic key_slot_i,
  input wire logic [cemc_pkg::KEY_IDX_W-1:0] key_idx_i,
  input wire logic [cemc_pkg::DATA_W-1:0] key_data_i,
  input wire logic key_stream_i,
  // Registered copy of device status and completion, and the stale key flag.
  output logic [cemc_pkg::ST_W-1:0] status_o,
  output logic done_o,
  output logic nap_key_stale_o
);
  // Registered link drives and status captures.
  logic req_q;
  logic nap_q;
  logic [7:0] words_q;
  logic kwe_q;
  logic kslot_q;
  logic [cemc_pkg::KEY_IDX_W-1:0] kidx_q;
  logic [cemc_pkg::DATA_W-1:0] kdata_q;
  logic kfifo_q;
  logic [cemc_pkg::ST_W-1:0] status_q;
  logic done_q;
  // Set by a non-approved command until a fresh key is loaded.
  logic stale_q;

  // A non-approved command after an earlier one needs a fresh non-approved key first.
  wire nap_block = cmd_nonapproved_i && stale_q;
  wire fresh_key = (key_we_i || key_stream_i) && key_slot_i;

  // Streams pass straight through; the device queues do the buffering.
  assign link.in_data = tx_data_i;
  assign link.in_valid = tx_valid_i;
  assign tx_ready_o = link.in_ready;
  assign rx_data_o = link.out_data;
  assign rx_valid_o = link.out_valid;
  assign link.out_ready = rx_ready_i;

  // Command and key registers toward the device.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_q <= 1'b0;
      nap_q <= 1'b0;
      words_q <= 8'h00;
      kwe_q <= 1'b0;
      kslot_q <= 1'b0;
      kidx_q <= '0;
      kdata_q <= cemc_pkg::KEY_ZERO;
      kfifo_q <= 1'b0;
    end
    else
    begin
      req_q <= cmd_i && !nap_block;
      nap_q <= cmd_nonapproved_i;
      words_q <= cmd_words_i;
      kwe_q <= key_we_i;
      kslot_q <= key_slot_i;
      kidx_q <= key_idx_i;
      kdata_q <= key_data_i;
      kfifo_q <= key_stream_i;
    end
  end

  // Status capture and the stale key tracker; reset clears lock.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_q <= '0;
      done_q <= 1'b0;
      stale_q <= 1'b0;
    end
    else
    begin
      status_q <= link.status;
      done_q <= link.done;
      // A fresh key in the same cycle wins over the stale mark.
      if (fresh_key) stale_q <= 1'b0;
      else if (cmd_i && cmd_nonapproved_i && !stale_q) stale_q <= 1'b1;
    end
  end

  assign link.req = req_q;
  assign link.req_nonapproved = nap_q;
  assign link.req_words = words_q;
  assign link.key_we = kwe_q;
  assign link.key_slot = kslot_q;
  assign link.key_idx = kidx_q;
  assign link.key_data = kdata_q;
  assign link.key_from_fifo = kfifo_q;
  assign status_o = status_q;
  assign done_o = done_q;
  assign nap_key_stale_o = stale_q;
endmodule : cemc_host

// *** cemc_chk.sv ***
// Checker of the link rules between the device end and the host end.
`timescale 1ns/1ps
module cemc_chk (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Link signals that are watched.
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic req,
  input wire logic req_nonapproved,
  input wire logic [cemc_pkg::ST_W-1:0] status,
  input wire logic done
);
  // One clock domain, so clocking and disable are given once.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Named status bits keep the properties readable.
  wire logic rdy = status[cemc_pkg::ST_READY];
  wire logic appr = status[cemc_pkg::ST_APPROVED];
  wire logic lck = status[cemc_pkg::ST_LOCKED];
  wire logic busy = status[cemc_pkg::ST_BUSY];
  wire logic refd = status[cemc_pkg::ST_REFUSED];

  // Reset leaves a clean, empty and silent link.
  property p_rst_idle;
    $fell(rst_i) |-> status == 5'h00 && !out_valid && in_ready && !done;
  endproperty
  // Ready is only ever shown in approved mode.
  property p_ready_appr;
    rdy |-> appr;
  endproperty
  // A locked device offers nothing.
  property p_lock_excl;
    lck |-> !rdy && !appr;
  endproperty
  // Only reset leaves the lock.
  property p_lock_hold;
    lck |=> lck;
  endproperty
  // Requests made while locked are refused.
  property p_lock_refuse;
    lck && req |-> ##[1:2] refd;
  endproperty
  // Nothing leaves a locked device.
  property p_lock_quiet;
    lck |-> !out_valid && !done;
  endproperty
  // A non-approved request drops approved mode without a mode command.
  property p_nap_mode;
    req && req_nonapproved && rdy |-> ##[1:3] !appr;
  endproperty
  // An approved request keeps approved mode.
  property p_app_stay;
    req && !req_nonapproved && rdy |=> appr [*3];
  endproperty
  // An accepted request makes the engine busy.
  property p_busy_ans;
    req && rdy |-> ##[1:2] busy;
  endproperty
  // Completion returns to approved mode within three cycles.
  property p_done_back;
    done |-> ##[0:3] (rdy && appr);
  endproperty

  a_rst_idle: assert property (p_rst_idle)
    else $error("link not idle after reset");
  a_ready_appr: assert property (p_ready_appr)
    else $error("ready shown outside approved mode");
  a_lock_excl: assert property (p_lock_excl)
    else $error("locked device still offers service");
  a_lock_hold: assert property (p_lock_hold)
    else $error("lock released without reset");
  a_lock_refuse: assert property (p_lock_refuse)
    else $error("request in lock not refused");
  a_lock_quiet: assert property (p_lock_quiet)
    else $error("output while locked");
  a_nap_mode: assert property (p_nap_mode)
    else $error("non-approved request kept approved mode");
  a_app_stay: assert property (p_app_stay)
    else $error("approved request left approved mode");
  a_busy_ans: assert property (p_busy_ans)
    else $error("accepted request did not go busy");
  a_done_back: assert property (p_done_back)
    else $error("no return to approved mode after done");

  // Main scenarios that the bench is meant to reach.
  c_nap_done: cover property (req && req_nonapproved ##[1:60] done);
  c_locked: cover property ($rose(lck));
  c_refused: cover property (refd);
  c_full: cover property (in_valid && !in_ready);
endmodule : cemc_chk

// *** cemc_tb_top.sv ***
// Self-checking testbench joining both ends of the crypto control link.
`timescale 1ns/1ps
module cemc_tb_top;
  // Clock, reset and test engine outcome.
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic kat_done = 1'b0;
  logic kat_pass = 1'b0;
  // User side of the host end.
  logic [cemc_pkg::DATA_W-1:0] tx_data = 32'h0000_0000;
  logic tx_valid = 1'b0;
  logic tx_ready;
  logic [cemc_pkg::DATA_W-1:0] rx_data;
  logic rx_valid;
  logic rx_ready = 1'b1;
  logic cmd = 1'b0;
  logic cmd_nap = 1'b0;
  logic [7:0] cmd_words = 8'h01;
  logic key_we = 1'b0;
  logic key_slot = 1'b0;
  logic [cemc_pkg::KEY_IDX_W-1:0] key_idx = 3'h0;
  logic [cemc_pkg::DATA_W-1:0] key_data = 32'h0000_0000;
  logic key_stream = 1'b0;
  logic [cemc_pkg::ST_W-1:0] status;
  logic done;
  logic stale;
  logic approved;
  // Bookkeeping; the two seeds keep both random users repeatable.
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int rx_cnt = 0;
  int done_cnt = 0;
  int ref_cnt = 0;
  int low_cnt = 0;
  bit stall = 1'b0;
  logic [31:0] seed_a = 32'h0000_0001;
  logic [31:0] seed_b = 32'h0000_0001;
  // Last word taken from the output stream.
  logic [31:0] rx_last = 32'h0000_0000;
  // Expected approved key word one; reset zeroizes it again.
  logic [31:0] app_k1 = 32'h0000_0000;

  cemc_if cemc_if_inst ();
  cemc_dev cemc_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .link(cemc_if_inst),
    .kat_done_i(kat_done), .kat_pass_i(kat_pass), .approved_o(approved));
  cemc_host cemc_host_inst (.clk_i(clk_i), .rst_i(rst_i),
    .link(cemc_if_inst), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready), .cmd_i(cmd), .cmd_nonapproved_i(cmd_nap),
    .cmd_words_i(cmd_words), .key_we_i(key_we), .key_slot_i(key_slot),
    .key_idx_i(key_idx), .key_data_i(key_data), .key_stream_i(key_stream),
    .status_o(status), .done_o(done), .nap_key_stale_o(stale));
  cemc_chk cemc_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
    .in_valid(cemc_if_inst.in_valid), .in_ready(cemc_if_inst.in_ready),
    .out_valid(cemc_if_inst.out_valid), .req(cemc_if_inst.req),
    .req_nonapproved(cemc_if_inst.req_nonapproved),
    .status(cemc_if_inst.status), .done(cemc_if_inst.done));

  // Free-running 100 MHz clock.
  always #5 clk_i = ~clk_i;

  // Xorshift step used for all random values.
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  // Whether approved mode must dip during a service of this kind.
  function automatic logic [31:0] exp_dip(input bit nap);
    return nap ? 32'h0000_0001 : 32'h0000_0000;
  endfunction : exp_dip

  // Last output word of a service; one word left selects key word one.
  function automatic logic [31:0] exp_last(input logic [31:0] d,
                                           input logic [31:0] k);
    return d ^ k ^ 32'h0101_0101;
  endfunction : exp_last

  // Monitor and random output stall; also cuts a hang short.
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    seed_a <= xs(seed_a);
    rx_ready <= !stall && (seed_a[1:0] != 2'b00);
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
    begin
      rx_cnt <= rx_cnt + 1;
      rx_last <= rx_data;
    end
    if (done === 1'b1)
      done_cnt <= done_cnt + 1;
    if (status[cemc_pkg::ST_REFUSED] === 1'b1)
      ref_cnt <= ref_cnt + 1;
    if (approved !== 1'b1)
      low_cnt <= low_cnt + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      close_out();
    end
  end

  // Compare one value and report a mismatch at once.
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Apply reset for six cycles with the given test outcome.
  task automatic do_reset(input bit pass);
    @(posedge clk_i);
    rst_i <= 1'b1;
    kat_done <= 1'b1;
    kat_pass <= pass;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : do_reset

  // Wait a bounded time for the ready status.
  task automatic wait_ready();
    int n;
    n = 0;
    while (status[cemc_pkg::ST_READY] !== 1'b1 && n < 100)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("ready", 1, status[cemc_pkg::ST_READY]);
  endtask : wait_ready

  // One-cycle service command.
  task automatic send_cmd(input bit nap, input int n);
    @(posedge clk_i);
    cmd <= 1'b1;
    cmd_nap <= nap;
    cmd_words <= n[7:0];
    @(posedge clk_i);
    cmd <= 1'b0;
  endtask : send_cmd

  // Register write of one key word.
  task automatic key_wr(input logic s, input int i, input logic [31:0] d);
    @(posedge clk_i);
    key_we <= 1'b1;
    key_slot <= s;
    key_idx <= i[2:0];
    key_data <= d;
    @(posedge clk_i);
    key_we <= 1'b0;
  endtask : key_wr

  // Offer a word; valid stays up if the bound runs out unanswered.
  task automatic push(input logic [31:0] d, input int lim, output bit ok);
    int n;
    n = 0;
    @(posedge clk_i);
    tx_data <= d;
    tx_valid <= 1'b1;
    do
    begin
      @(negedge clk_i);
      n++;
    end while (tx_ready !== 1'b1 && n < lim);
    ok = (tx_ready === 1'b1);
    @(posedge clk_i);
    if (ok)
      tx_valid <= 1'b0;
  endtask : push

  // Full service: non-approved key when nap is set, command, words in, words out, completion.
  task automatic svc(input bit nap, input int n);
    int k;
    int r0;
    int d0;
    int l0;
    bit ok;
    bit filled;
    logic [31:0] d;
    logic [31:0] k1;
    r0 = rx_cnt;
    d0 = done_cnt;
    filled = 1'b0;
    // Key word one of the slot that this service must use.
    k1 = nap ? (seed_b ^ 32'h0000_0001) : app_k1;
    if (nap)
      for (k = 0; k < 8; k++) key_wr(1'b1, k, seed_b ^ k);
    wait_ready();
    l0 = low_cnt;
    send_cmd(nap, n);
    for (k = 0; k < n; k++)
    begin
      seed_b = xs(seed_b);
      d = seed_b;
      push(d, 8, ok);
      if (!ok && stall)
      begin
        chk("fill_depth", 1, k >= cemc_pkg::FIFO_DEPTH);
        filled = 1'b1;
        stall = 1'b0;
      end
      if (!ok)
        push(d, 200, ok);
    end
    if (n > 30)
      chk("fill_refused", 1, filled);
    stall = 1'b0;
    k = 0;
    // Done comes when the last word is queued, not when it is taken.
    while ((done_cnt == d0 || rx_cnt < r0 + n) && k < 400)
    begin
      @(negedge clk_i);
      k++;
    end
    chk("words_out", r0 + n, rx_cnt);
    chk("done_count", d0 + 1, done_cnt);
    chk("mode_dip", exp_dip(nap), low_cnt > l0);
    wait_ready();
    chk("back_approved", 1, approved);
    chk("last_word", exp_last(d, k1), rx_last);
    if (nap) chk("nap_stale", 1, stale);
    $display("Test service nap=%0d words=%0d ended", nap, n);
  endtask : svc

  // Ends the run with the counts and the verdict.
  task close_out();
    $display("Counts: %0d checks, %0d mismatches", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // Main sequence of scenarios.
  initial
  begin
    int i;
    int r0;
    bit ok;
    do_reset(1'b1);
    repeat (10) @(negedge clk_i);
    chk("early_mode", 0, approved);
    r0 = ref_cnt;
    send_cmd(1'b0, 1);
    repeat (4) @(negedge clk_i);
    chk("early_refused", 1, ref_cnt > r0);
    wait_ready();
    chk("approved_up", 1, approved);
    $display("Test power-up ended");
    svc(1'b1, 1);
    svc(1'b1, 1);
    // A second non-approved command without a fresh key must not start.
    send_cmd(1'b1, 1);
    repeat (4) @(negedge clk_i);
    chk("nap_blocked", 0, status[cemc_pkg::ST_BUSY]);
    svc(1'b0, 1);
    for (i = 0; i < 6; i++)
    begin
      seed_b = xs(seed_b);
      svc(seed_b[4], 1 + int'(seed_b[11:8]));
    end
    stall = 1'b1;
    svc(1'b0, 40);
    wait_ready();
    r0 = rx_cnt;
    @(posedge clk_i);
    key_stream <= 1'b1;
    key_slot <= 1'b0;
    @(posedge clk_i);
    key_stream <= 1'b0;
    for (i = 0; i < cemc_pkg::KEY_WORDS; i++) push(32'hA5A5_0000 + i, 50, ok);
    repeat (20) @(negedge clk_i);
    chk("key_load_silent", r0, rx_cnt);
    app_k1 = 32'hA5A5_0001;
    svc(1'b0, 2);
    $display("Test stream key load ended");
    do_reset(1'b0);
    app_k1 = 32'h0000_0000;
    repeat (60) @(negedge clk_i);
    chk("locked", 1, status[cemc_pkg::ST_LOCKED]);
    r0 = ref_cnt;
    i = rx_cnt;
    send_cmd(1'b0, 1);
    repeat (6) @(negedge clk_i);
    chk("lock_refused", 1, ref_cnt > r0);
    chk("lock_silent", i, rx_cnt);
    chk("lock_mode", 0, approved);
    do_reset(1'b1);
    wait_ready();
    svc(1'b0, 3);
    $display("Test lock and recovery ended");
    close_out();
  end
endmodule : cemc_tb_top
